// ===== uart_defs.svh
// Purpose: Shared constants of the host serial frame interface
// Assumes: 20 MHz core clock, 1 Mbit/s link
// Notes: Definitions only
`ifndef UART_DEFS_SVH
`define UART_DEFS_SVH

// ****************************************
// Timing
// ****************************************
`define UART_CLK_NS 50
`define UART_BIT_NS 1000
`define UART_BIT_CYC (`UART_BIT_NS / `UART_CLK_NS)
`define UART_BREAK_BITS 11

// ****************************************
// Frame fields
// ****************************************
`define UART_KIND_BIT 7
`define UART_REQ_READ 3'h0
`define UART_REQ_WRITE 3'h1
`define UART_CRC_INIT 16'hffff
`define UART_CRC_POLY 16'ha001
`define UART_FIFO_DEPTH 8

// ****************************************
// Response byte sequence
// ****************************************
`define UART_STEP_HDR 3'h0
`define UART_STEP_DEV 3'h1
`define UART_STEP_AHI 3'h2
`define UART_STEP_ALO 3'h3
`define UART_STEP_DATA 3'h4
`define UART_STEP_CLO 3'h5
`define UART_STEP_CHI 3'h6

`endif

// ===== uart_pkg.sv
// Purpose: Types of the host serial frame interface
// Assumes: Nothing
// Notes: State vectors of the receiver and the frame interface module
`default_nettype none
package uart_pkg;

	// ****************************************
	// State encodings
	// ****************************************
	typedef enum logic [2:0] {
		ST_RECV = 3'h1,
		ST_WR = 3'h2,
		ST_RESP = 3'h4
	} frame_state_t;

	typedef enum logic [3:0] {
		TX_IDLE = 4'h1,
		TX_START = 4'h2,
		TX_DATA = 4'h4,
		TX_STOP = 4'h8
	} tx_state_t;

	typedef enum logic [3:0] {
		RX_IDLE = 4'h1,
		RX_START = 4'h2,
		RX_DATA = 4'h4,
		RX_STOP = 4'h8
	} rx_state_t;

	// ****************************************
	// Module state vectors
	// ****************************************
	typedef struct packed {
		logic sync1;
		logic sync2;
		logic sync3;
		logic line;
		logic line_prev;
		rx_state_t st;
		logic [4:0] cnt;
		logic [2:0] bitn;
		logic [7:0] sh;
		logic [7:0] lowcnt;
		logic brk_done;
		logic valid;
		logic [7:0] data;
		logic serr;
		logic brk;
	} rx_st_t;

	typedef struct packed {
		frame_state_t fst;
		logic [3:0] idx;
		logic [7:0] hdr;
		logic [7:0] dev;
		logic [15:0] radr;
		logic [15:0] raddr;
		logic [7:0][7:0] wbuf;
		logic [15:0] crc;
		logic [15:0] tcrc;
		logic [6:0] left;
		logic [2:0] wi;
		logic sub;
		logic [2:0] rstep;
		logic [7:0] rbyte;
		logic rvalid;
		logic [6:0] rlen;
		logic counting;
		logic [4:0] hdiv;
		logic [8:0] hold;
		logic tx_en;
		tx_state_t tst;
		logic [4:0] txc;
		logic [7:0] tsh;
		logic [2:0] tbit;
		logic stop2;
		logic tx;
		logic serr_f;
		logic seen_f;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} main_st_t;

endpackage : uart_pkg
`default_nettype wire

// ===== byte_stream_if.sv
// Purpose: Valid/ready byte stream between internal modules
// Assumes: Single clock
// Notes: Transfer when valid and ready are both high
`timescale 1ns/1ps
`default_nettype none
interface byte_stream_if #(
	parameter int W = 8
);
	logic valid;
	logic ready;
	logic [W-1:0] data;
	modport src(output valid, output data, input ready);
	modport snk(input valid, input data, output ready);
endinterface : byte_stream_if
`default_nettype wire

// ===== byte_fifo.sv
// Purpose: Small synchronous FIFO for the response byte stream
// Assumes: Depth is a power of two
// Notes: Flush empties it in one cycle
`timescale 1ns/1ps
`default_nettype none
`include "uart_defs.svh"
module byte_fifo #(
	parameter int W = 8,
	parameter int D = `UART_FIFO_DEPTH
) (
	input wire logic i_clock,
	input wire logic i_rst,
	input wire logic i_flush,
	byte_stream_if.snk in_s,
	byte_stream_if.src out_s
);
	import uart_pkg::*;
	localparam int AW = $clog2(D);
	localparam logic [AW:0] CNT_FULL = (AW+1)'(D);

	typedef struct packed {
		logic [D-1:0][W-1:0] mem;
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0] cnt;
	} fifo_st_t;

	fifo_st_t fifo_r;
	fifo_st_t fifo_nxt;
	logic push;
	logic pop;

	assign in_s.ready = (fifo_r.cnt != CNT_FULL);
	assign out_s.valid = (fifo_r.cnt != '0);
	assign out_s.data = fifo_r.mem[fifo_r.rp];
	assign push = in_s.valid && in_s.ready;
	assign pop = out_s.valid && out_s.ready;

	always_comb begin
		fifo_nxt = fifo_r;
		if (push) begin
			fifo_nxt.mem[fifo_r.wp] = in_s.data;
			fifo_nxt.wp = fifo_r.wp + 1'b1;
		end
		if (pop) begin
			fifo_nxt.rp = fifo_r.rp + 1'b1;
		end
		if (push && !pop) begin
			fifo_nxt.cnt = fifo_r.cnt + 1'b1;
		end else if (pop && !push) begin
			fifo_nxt.cnt = fifo_r.cnt - 1'b1;
		end
		if (i_flush) begin
			fifo_nxt.wp = '0;
			fifo_nxt.rp = '0;
			fifo_nxt.cnt = '0;
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			fifo_r <= '0;
		end else begin
			fifo_r <= fifo_nxt;
		end
	end
endmodule : byte_fifo
`default_nettype wire

// ===== uart_rx_byte.sv
// Purpose: Serial byte receiver with break detection
// Assumes: Line idles high, LSB first
// Notes: Samples each bit in its middle
`timescale 1ns/1ps
`default_nettype none
`include "uart_defs.svh"
module uart_rx_byte (
	input wire logic i_clock,
	input wire logic i_rst,
	input wire logic i_rx,
	input wire logic i_ignore,
	input wire logic i_clear,
	output logic o_byte_valid,
	output logic [7:0] o_byte,
	output logic o_stop_err,
	output logic o_break
);
	import uart_pkg::*;
	localparam logic [4:0] BIT_LAST = 5'(`UART_BIT_CYC - 1);
	localparam logic [4:0] HALF_LAST = 5'(`UART_BIT_CYC / 2 - 1);
	localparam logic [7:0] BRK_LAST = 8'(`UART_BREAK_BITS * `UART_BIT_CYC - 1);

	rx_st_t rx_r;
	rx_st_t rx_nxt;

	assign o_byte_valid = rx_r.valid;
	assign o_byte = rx_r.data;
	assign o_stop_err = rx_r.serr;
	assign o_break = rx_r.brk;

	always_comb begin
		rx_nxt = rx_r;
		rx_nxt.sync1 = i_rx;
		rx_nxt.sync2 = rx_r.sync1;
		rx_nxt.sync3 = rx_r.sync2;
		if (rx_r.sync2 == rx_r.sync3) begin
			rx_nxt.line = rx_r.sync3;
		end
		rx_nxt.line_prev = rx_r.line;
		rx_nxt.valid = 1'b0;
		rx_nxt.serr = 1'b0;
		rx_nxt.brk = 1'b0;
		case (rx_r.st)
			RX_IDLE: begin
				rx_nxt.cnt = '0;
				// Start is a falling edge, so extra stop bits just idle
				if (rx_r.line_prev && !rx_r.line && !i_ignore) begin
					rx_nxt.st = RX_START;
				end
			end
			RX_START: begin
				if (rx_r.cnt == HALF_LAST) begin
					rx_nxt.cnt = '0;
					rx_nxt.bitn = '0;
					rx_nxt.st = rx_r.line ? RX_IDLE : RX_DATA;
				end else begin
					rx_nxt.cnt = rx_r.cnt + 1'b1;
				end
			end
			RX_DATA: begin
				if (rx_r.cnt == BIT_LAST) begin
					rx_nxt.cnt = '0;
					rx_nxt.sh = {rx_r.line, rx_r.sh[7:1]};
					rx_nxt.bitn = rx_r.bitn + 1'b1;
					if (rx_r.bitn == 3'h7) begin
						rx_nxt.st = RX_STOP;
					end
				end else begin
					rx_nxt.cnt = rx_r.cnt + 1'b1;
				end
			end
			RX_STOP: begin
				if (rx_r.cnt == BIT_LAST) begin
					rx_nxt.valid = 1'b1;
					rx_nxt.data = rx_r.sh;
					rx_nxt.serr = !rx_r.line;
					rx_nxt.st = RX_IDLE;
				end else begin
					rx_nxt.cnt = rx_r.cnt + 1'b1;
				end
			end
			default: begin
				rx_nxt.st = RX_IDLE;
			end
		endcase
		// Long low level is a break, seen even while transmitting
		if (rx_r.line) begin
			rx_nxt.lowcnt = '0;
			rx_nxt.brk_done = 1'b0;
		end else if (!rx_r.brk_done) begin
			if (rx_r.lowcnt == BRK_LAST) begin
				rx_nxt.brk = 1'b1;
				rx_nxt.brk_done = 1'b1;
				rx_nxt.st = RX_IDLE;
				rx_nxt.valid = 1'b0;
			end else begin
				rx_nxt.lowcnt = rx_r.lowcnt + 1'b1;
			end
		end
		if (i_clear) begin
			rx_nxt.st = RX_IDLE;
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			rx_r <= '0;
			rx_r.sync1 <= 1'b1;
			rx_r.sync2 <= 1'b1;
			rx_r.sync3 <= 1'b1;
			rx_r.line <= 1'b1;
			rx_r.line_prev <= 1'b1;
			rx_r.st <= RX_IDLE;
		end else begin
			rx_r <= rx_nxt;
		end
	end

	a_rx_ignore_tx: assert property (
		@(posedge i_clock) disable iff (i_rst)
		(i_ignore && rx_r.st == RX_IDLE) |=> (rx_r.st == RX_IDLE))
		else $error("receiver started a byte while transmitting");

	a_rx_stop_low: assert property (
		@(posedge i_clock) disable iff (i_rst)
		(rx_r.st == RX_STOP && rx_r.cnt == BIT_LAST && !rx_r.line && !i_clear
			&& !(rx_r.lowcnt == BRK_LAST && !rx_r.brk_done)) |=> rx_r.serr)
		else $error("low stop bit not reported");
endmodule : uart_rx_byte
`default_nettype wire

// ===== uart_host_frame_interface.sv
// Purpose: Host serial frame interface: framing, command decode, response
// Assumes: Register map answers combinationally on o_reg_addr
// Notes: Response bytes pass an 8-entry FIFO before the transmitter
// ****************************************
// ****************************************
`timescale 1ns/1ps
`default_nettype none
`include "uart_defs.svh"
module uart_host_frame_interface (
	input wire logic i_clock,
	input wire logic i_rst,
	input wire logic i_rx,
	output logic o_tx,
	input wire logic i_double_stop_enable,
	input wire logic [7:0] i_turnaround_bits,
	input wire logic i_direction_select,
	input wire logic [5:0] i_primary_direction_id,
	input wire logic [5:0] i_secondary_direction_id,
	input wire logic i_wake_ping,
	input wire logic i_in_sleep,
	input wire logic i_clear_stop_flag,
	input wire logic i_clear_seen_flag,
	output logic o_stop_bit_error_flag,
	output logic o_clear_seen_flag,
	output logic [15:0] o_reg_addr,
	output logic [7:0] o_reg_wdata,
	output logic o_reg_wr,
	output logic o_reg_rd,
	input wire logic [7:0] i_reg_rdata,
	input wire logic i_reg_addr_ok,
	output logic o_tx_active
);
	import uart_pkg::*;
	localparam logic [4:0] BIT_LAST = 5'(`UART_BIT_CYC - 1);
	localparam logic [4:0] HALF_START = 5'(`UART_BIT_CYC / 2);

	// ****************************************
	// Declarations
	// ****************************************
	main_st_t st_r;
	main_st_t st_nxt;
	logic rx_valid;
	logic [7:0] rx_byte;
	logic rx_serr;
	logic rx_brk;
	logic clr;
	logic [5:0] id_sel;
	logic [15:0] rx_crc;
	logic [3:0] last_idx;
	logic cmd_ok;
	logic [7:0] push_byte;
	logic push_valid;
	logic push;
	logic pop;
	logic bit_end;
	logic set_stop;
	logic set_seen;

	byte_stream_if #(.W(8)) fin();
	byte_stream_if #(.W(8)) fout();

	function automatic logic [15:0] crc_byte(input logic [15:0] c_in, input logic [7:0] b);
		logic [15:0] c;
		c = c_in ^ {8'h00, b};
		for (int k = 0; k < 8; k++) begin
			c = c[0] ? ((c >> 1) ^ `UART_CRC_POLY) : (c >> 1);
		end
		return c;
	endfunction : crc_byte

	// ****************************************
	// Submodules
	// ****************************************
	uart_rx_byte u_rx (
		.i_clock(i_clock),
		.i_rst(i_rst),
		.i_rx(i_rx),
		.i_ignore(st_r.tx_en),
		.i_clear(i_wake_ping),
		.o_byte_valid(rx_valid),
		.o_byte(rx_byte),
		.o_stop_err(rx_serr),
		.o_break(rx_brk)
	);

	byte_fifo #(.W(8), .D(`UART_FIFO_DEPTH)) u_fifo (
		.i_clock(i_clock),
		.i_rst(i_rst),
		.i_flush(clr),
		.in_s(fin),
		.out_s(fout)
	);

	// ****************************************
	// Decode helpers
	// ****************************************
	assign clr = rx_brk || i_wake_ping;
	assign id_sel = i_direction_select ? i_secondary_direction_id : i_primary_direction_id;
	assign rx_crc = crc_byte((st_r.idx == 4'h0) ? `UART_CRC_INIT : st_r.crc, rx_byte);
	assign last_idx = {1'b0, st_r.hdr[2:0]} + 4'h6;
	assign cmd_ok = (rx_crc == 16'h0000) && st_r.hdr[`UART_KIND_BIT]
		&& (st_r.dev == {2'b00, id_sel})
		&& ((st_r.hdr[6:4] == `UART_REQ_READ) || (st_r.hdr[6:4] == `UART_REQ_WRITE));
	assign set_stop = rx_serr || rx_brk || (i_wake_ping && !i_in_sleep);
	assign set_seen = rx_brk || i_wake_ping;

	always_comb begin
		push_byte = 8'h00;
		case (st_r.rstep)
			`UART_STEP_HDR: push_byte = {1'b0, st_r.rlen};
			`UART_STEP_DEV: push_byte = {2'b00, id_sel};
			`UART_STEP_AHI: push_byte = st_r.radr[15:8];
			`UART_STEP_ALO: push_byte = st_r.radr[7:0];
			`UART_STEP_DATA: push_byte = st_r.rbyte;
			`UART_STEP_CLO: push_byte = st_r.tcrc[7:0];
			`UART_STEP_CHI: push_byte = st_r.tcrc[15:8];
			default: push_byte = 8'h00;
		endcase
	end

	assign push_valid = (st_r.fst == ST_RESP) && ((st_r.rstep != `UART_STEP_DATA) || st_r.rvalid);
	assign fin.valid = push_valid;
	assign fin.data = push_byte;
	assign push = push_valid && fin.ready;
	assign fout.ready = (st_r.tst == TX_IDLE) && st_r.tx_en;
	assign pop = fout.valid && fout.ready;
	assign bit_end = (st_r.txc == BIT_LAST);

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		st_nxt = st_r;
		st_nxt.wr = 1'b0;
		st_nxt.rd = 1'b0;
		case (st_r.fst)
			ST_RECV: begin
				if (rx_valid) begin
					st_nxt.crc = rx_crc;
					case (st_r.idx)
						4'h0: st_nxt.hdr = rx_byte;
						4'h1: st_nxt.dev = rx_byte;
						4'h2: st_nxt.radr[15:8] = rx_byte;
						4'h3: st_nxt.radr[7:0] = rx_byte;
						default: begin
							if ((st_r.idx - 4'h4) <= {1'b0, st_r.hdr[2:0]}) begin
								st_nxt.wbuf[3'(st_r.idx - 4'h4)] = rx_byte;
							end
						end
					endcase
					if (st_r.idx != 4'h0 && st_r.idx == last_idx) begin
						st_nxt.idx = 4'h0;
						if (cmd_ok && st_r.hdr[6:4] == `UART_REQ_READ) begin
							st_nxt.fst = ST_RESP;
							st_nxt.rstep = `UART_STEP_HDR;
							st_nxt.rlen = st_r.wbuf[0][6:0];
							st_nxt.left = st_r.wbuf[0][6:0];
							st_nxt.raddr = st_r.radr;
							st_nxt.rvalid = 1'b0;
							st_nxt.counting = 1'b1;
							st_nxt.hdiv = HALF_START;
							st_nxt.hold = '0;
						end else if (cmd_ok) begin
							st_nxt.fst = ST_WR;
							st_nxt.raddr = st_r.radr;
							st_nxt.left = {4'h0, st_r.hdr[2:0]};
							st_nxt.wi = '0;
							st_nxt.sub = 1'b0;
						end
					end else begin
						st_nxt.idx = st_r.idx + 4'h1;
					end
				end
			end
			ST_WR: begin
				if (!st_r.sub) begin
					st_nxt.wdata = st_r.wbuf[st_r.wi];
					st_nxt.wr = i_reg_addr_ok;
					st_nxt.sub = 1'b1;
				end else begin
					st_nxt.sub = 1'b0;
					st_nxt.raddr = st_r.raddr + 16'h0001;
					st_nxt.wi = st_r.wi + 3'h1;
					st_nxt.left = st_r.left - 7'h01;
					if (st_r.left == 7'h00) begin
						st_nxt.fst = ST_RECV;
					end
				end
			end
			ST_RESP: begin
				if (st_r.rstep == `UART_STEP_DATA && !st_r.rvalid) begin
					st_nxt.rbyte = i_reg_addr_ok ? i_reg_rdata : 8'h00;
					st_nxt.rvalid = 1'b1;
					st_nxt.rd = 1'b1;
				end
				if (push) begin
					if (st_r.rstep <= `UART_STEP_DATA) begin
						st_nxt.tcrc = crc_byte((st_r.rstep == `UART_STEP_HDR) ? `UART_CRC_INIT
							: st_r.tcrc, push_byte);
					end
					if (st_r.rstep == `UART_STEP_DATA) begin
						st_nxt.rvalid = 1'b0;
						st_nxt.raddr = st_r.raddr + 16'h0001;
						st_nxt.left = st_r.left - 7'h01;
						if (st_r.left == 7'h00) begin
							st_nxt.rstep = `UART_STEP_CLO;
						end
					end else if (st_r.rstep == `UART_STEP_CHI) begin
						st_nxt.fst = ST_RECV;
					end else begin
						st_nxt.rstep = st_r.rstep + 3'h1;
					end
				end
			end
			default: begin
				st_nxt.fst = ST_RECV;
			end
		endcase

		// Turnaround: first tick marks end of the last stop bit
		if (st_r.counting) begin
			st_nxt.hdiv = (st_r.hdiv == BIT_LAST) ? 5'h00 : st_r.hdiv + 5'h01;
			if (st_r.hdiv == BIT_LAST) begin
				if (st_r.hold == {1'b0, i_turnaround_bits}) begin
					st_nxt.tx_en = 1'b1;
					st_nxt.counting = 1'b0;
				end else begin
					st_nxt.hold = st_r.hold + 9'h001;
				end
			end
		end
		if (st_r.tx_en && st_r.fst == ST_RECV && !fout.valid && st_r.tst == TX_IDLE) begin
			st_nxt.tx_en = 1'b0;
		end

		// Transmitter
		st_nxt.txc = (bit_end || st_r.tst == TX_IDLE) ? 5'h00 : st_r.txc + 5'h01;
		case (st_r.tst)
			TX_IDLE: begin
				st_nxt.tx = 1'b1;
				if (pop) begin
					st_nxt.tsh = fout.data;
					st_nxt.tx = 1'b0;
					st_nxt.tst = TX_START;
				end
			end
			TX_START: begin
				if (bit_end) begin
					st_nxt.tst = TX_DATA;
					st_nxt.tx = st_r.tsh[0];
					st_nxt.tbit = 3'h0;
				end
			end
			TX_DATA: begin
				if (bit_end) begin
					if (st_r.tbit == 3'h7) begin
						st_nxt.tst = TX_STOP;
						st_nxt.tx = 1'b1;
						st_nxt.stop2 = i_double_stop_enable;
					end else begin
						st_nxt.tbit = st_r.tbit + 3'h1;
						st_nxt.tsh = {1'b0, st_r.tsh[7:1]};
						st_nxt.tx = st_r.tsh[1];
					end
				end
			end
			TX_STOP: begin
				if (bit_end) begin
					if (st_r.stop2) begin
						st_nxt.stop2 = 1'b0;
					end else begin
						st_nxt.tst = TX_IDLE;
					end
				end
			end
			default: begin
				st_nxt.tst = TX_IDLE;
				st_nxt.tx = 1'b1;
			end
		endcase

		// Break or wake ping aborts everything; next byte is a header
		if (clr) begin
			st_nxt.fst = ST_RECV;
			st_nxt.idx = 4'h0;
			st_nxt.tst = TX_IDLE;
			st_nxt.tx = 1'b1;
			st_nxt.tx_en = 1'b0;
			st_nxt.counting = 1'b0;
			st_nxt.rvalid = 1'b0;
			st_nxt.stop2 = 1'b0;
			st_nxt.wr = 1'b0;
			st_nxt.rd = 1'b0;
		end

		// Sticky flags; a set in the clear cycle wins
		st_nxt.serr_f = (st_r.serr_f && !i_clear_stop_flag) || set_stop;
		st_nxt.seen_f = (st_r.seen_f && !i_clear_seen_flag) || set_seen;
	end

	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			st_r <= '0;
			st_r.fst <= ST_RECV;
			st_r.tst <= TX_IDLE;
			st_r.tx <= 1'b1;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign o_tx = st_r.tx;
	assign o_stop_bit_error_flag = st_r.serr_f;
	assign o_clear_seen_flag = st_r.seen_f;
	assign o_reg_addr = st_r.raddr;
	assign o_reg_wdata = st_r.wdata;
	assign o_reg_wr = st_r.wr;
	assign o_reg_rd = st_r.rd;
	assign o_tx_active = st_r.tx_en;

	// ****************************************
	// Assertions
	// ****************************************
	a_idle_line_high: assert property (
		@(posedge i_clock) disable iff (i_rst)
		(st_r.tst == TX_IDLE) |-> st_r.tx)
		else $error("transmit line not high while idle");

	a_start_bit_time: assert property (
		@(posedge i_clock) disable iff (i_rst)
		($rose(st_r.tst == TX_START) && !st_r.tx && !clr) |-> ##20 (st_r.tst == TX_DATA || !st_r.tx_en))
		else $error("start bit is not twenty cycles");

	a_two_stop_bits: assert property (
		@(posedge i_clock) disable iff (i_rst)
		($rose(st_r.tst == TX_STOP) && st_r.stop2) |-> ##39 (st_r.tst == TX_STOP || !st_r.tx_en))
		else $error("second stop bit missing");

	a_stop_flag_set: assert property (
		@(posedge i_clock) disable iff (i_rst)
		(rx_serr && i_clear_stop_flag) |=> o_stop_bit_error_flag)
		else $error("stop error lost against clear");

	a_break_flags: assert property (
		@(posedge i_clock) disable iff (i_rst)
		rx_brk |=> (o_clear_seen_flag && o_stop_bit_error_flag && st_r.tst == TX_IDLE && o_tx))
		else $error("break did not set flags or end transmission");

	a_wake_active: assert property (
		@(posedge i_clock) disable iff (i_rst)
		(i_wake_ping && !i_in_sleep) |=> (o_clear_seen_flag && o_stop_bit_error_flag))
		else $error("wake ping while active missed a flag");

	a_no_unasked_tx: assert property (
		@(posedge i_clock) disable iff (i_rst)
		(st_r.tst == TX_IDLE && !st_r.tx_en) |=> (st_r.tst == TX_IDLE))
		else $error("transmission without a read command");

	a_turnaround_wait: assert property (
		@(posedge i_clock) disable iff (i_rst)
		($rose(st_r.counting) && i_turnaround_bits == 8'h00 && !clr)
			|-> ##10 ($rose(st_r.tx_en) || clr || $past(clr)))
		else $error("turnaround gap wrong");

	a_reject_other_id: assert property (
		@(posedge i_clock) disable iff (i_rst)
		(st_r.fst == ST_RECV && rx_valid && st_r.idx != 4'h0 && st_r.idx == last_idx
			&& st_r.dev != {2'b00, id_sel}) |=> (st_r.fst == ST_RECV))
		else $error("answered a command for another address");
endmodule : uart_host_frame_interface
`default_nettype wire

// ===== host_model.sv
// Purpose: Host side of the serial link
// Assumes: 20 cycles per bit, line pulled up
// Notes: Drives at falling clock edge
`timescale 1ns/1ps
`default_nettype none
module host_model (
	input wire logic i_clock,
	input wire logic i_tx,
	output logic o_rx
);
	initial o_rx = 1'b1;
	task automatic send(input logic [7:0] b, input logic stp);
		o_rx = 1'b0;
		repeat (20) @(negedge i_clock);
		for (int i = 0; i < 8; i++) begin
			o_rx = b[i];
			repeat (20) @(negedge i_clock);
		end
		o_rx = stp;
		repeat (20) @(negedge i_clock);
		// Low stop bit: give the line one idle bit back
		if (!stp) begin
			o_rx = 1'b1;
			repeat (20) @(negedge i_clock);
		end
	endtask : send
	task automatic brk;
		o_rx = 1'b0;
		repeat (240) @(negedge i_clock);
		o_rx = 1'b1;
		repeat (200) @(negedge i_clock);
	endtask : brk
	task automatic recv(input logic two, output logic [7:0] b, output logic ok);
		int n;
		n = 0;
		ok = 1'b0;
		while (i_tx !== 1'b0 && n < 4000) begin
			@(negedge i_clock);
			n++;
		end
		repeat (10) @(negedge i_clock);
		ok = (i_tx === 1'b0);
		for (int i = 0; i < 8; i++) begin
			repeat (20) @(negedge i_clock);
			b[i] = i_tx;
		end
		repeat (20) @(negedge i_clock);
		ok = ok && (i_tx === 1'b1);
		if (two) begin
			repeat (20) @(negedge i_clock);
			ok = ok && (i_tx === 1'b1);
		end
		repeat (5) @(negedge i_clock);
	endtask : recv
endmodule : host_model
`default_nettype wire

// ===== test_uart_host_frame_interface.sv
// Purpose: Self-checking bench of the host frame interface
// Assumes: Register map modelled by an address pattern
// Notes: Address 0x0101 is invalid
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin mismatches++; \
	$display("wrong value at %0t: got %h exp %h", $time, a, e); end end
module test_uart_host_frame_interface;
	logic i_clock, i_rst, rx, tx, dse, dsel, wake, sleep, clr_s, clr_c;
	logic sflag, cflag, wr, rd, act, tx_seen;
	logic [15:0] adr;
	logic [7:0] wd, tab;
	logic [23:0] wq[$];
	int mismatches, checked, rd_n;
	uart_host_frame_interface u_uart_host_frame_interface (.i_clock(i_clock), .i_rst(i_rst),
		.i_rx(rx), .o_tx(tx), .i_double_stop_enable(dse), .i_turnaround_bits(tab),
		.i_direction_select(dsel), .i_primary_direction_id(6'h05),
		.i_secondary_direction_id(6'h2a), .i_wake_ping(wake), .i_in_sleep(sleep),
		.i_clear_stop_flag(clr_s), .i_clear_seen_flag(clr_c), .o_stop_bit_error_flag(sflag),
		.o_clear_seen_flag(cflag), .o_reg_addr(adr), .o_reg_wdata(wd), .o_reg_wr(wr),
		.o_reg_rd(rd), .i_reg_rdata(adr[7:0] ^ 8'h3c), .i_reg_addr_ok(adr != 16'h0101),
		.o_tx_active(act));
	host_model u_host_model (.i_clock(i_clock), .i_tx(tx), .o_rx(rx));
	initial begin
		i_clock = 1'b0;
		forever #25 i_clock = ~i_clock;
	end
	always @(posedge i_clock) begin
		if (wr === 1'b1) wq.push_back({adr, wd});
		if (tx === 1'b0) tx_seen = 1'b1;
		if (rd === 1'b1) rd_n++;
	end
	function automatic logic [15:0] crc(input logic [7:0] q[$]);
		logic [15:0] c;
		c = 16'hffff;
		foreach (q[i]) begin
			c ^= {8'h00, q[i]};
			repeat (8) c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
		end
		return c;
	endfunction : crc
	task automatic frame(input logic [7:0] q[$]);
		logic [15:0] c;
		c = crc(q);
		q.push_back(c[7:0]);
		q.push_back(c[15:8]);
		foreach (q[i]) u_host_model.send(q[i], 1'b1);
	endtask : frame
	task automatic t_write(input logic s, input logic [5:0] id, input logic [7:0] h, input int n);
		wq = {};
		tx_seen = 1'b0;
		dsel = s;
		frame('{h, {2'b00, id}, 8'h12, 8'h34, 8'ha5, 8'h5a});
		repeat (60) @(negedge i_clock);
		`CHK(wq.size(), n)
		if (n == 2) begin
			`CHK(wq[0], {16'h1234, 8'ha5})
			`CHK(wq[1], {16'h1235, 8'h5a})
		end
		`CHK(tx_seen, 1'b0)
	endtask : t_write
	task automatic t_read(input logic two);
		logic [7:0] b, r[$];
		logic ok;
		dse = two;
		dsel = 1'b0;
		tab = two ? 8'h02 : 8'h00;
		rd_n = 0;
		frame('{8'h80, 8'h05, 8'h01, 8'h00, 8'h01});
		for (int i = 0; i < 8; i++) begin
			u_host_model.recv(two, b, ok);
			`CHK(ok, 1'b1)
			if (ok !== 1'b1) final_report;
			r.push_back(b);
		end
		`CHK(act, 1'b1)
		repeat (20) @(negedge i_clock);
		`CHK(act, 1'b0)
		`CHK(rd_n, 2)
		`CHK(r[0], 8'h01)
		`CHK(r[1], 8'h05)
		`CHK({r[2], r[3]}, 16'h0100)
		`CHK(r[4], 8'h3c)
		`CHK(r[5], 8'h00)
		`CHK(crc(r), 16'h0000)
	endtask : t_read
	task automatic clear_flags;
		clr_s = 1'b1;
		clr_c = 1'b1;
		@(negedge i_clock);
		clr_s = 1'b0;
		clr_c = 1'b0;
		@(negedge i_clock);
		`CHK({sflag, cflag}, 2'b00)
	endtask : clear_flags
	task automatic t_break;
		logic [7:0] b;
		logic ok;
		dse = 1'b0;
		dsel = 1'b0;
		// Clear pulse ends on the cycle the low stop bit is flagged
		fork
			u_host_model.send(8'h81, 1'b0);
			begin
				repeat (193) @(negedge i_clock);
				clr_s = 1'b1;
				repeat (3) @(negedge i_clock);
				clr_s = 1'b0;
			end
		join
		`CHK(sflag, 1'b1)
		clear_flags;
		u_host_model.send(8'h05, 1'b1);
		u_host_model.brk;
		`CHK({sflag, cflag}, 2'b11)
		clear_flags;
		// Host talks over the response, then breaks it off
		frame('{8'h80, 8'h05, 8'h01, 8'h00, 8'h01});
		u_host_model.recv(1'b0, b, ok);
		`CHK(ok, 1'b1)
		if (ok !== 1'b1) final_report;
		u_host_model.send(8'h05, 1'b1);
		u_host_model.brk;
		`CHK({sflag, cflag, tx, act}, 4'b1110)
		clear_flags;
		t_write(1'b0, 6'h05, 8'h91, 2);
	endtask : t_break
	task automatic t_wake;
		for (int s = 0; s < 2; s++) begin
			sleep = s[0];
			wake = 1'b1;
			@(negedge i_clock);
			wake = 1'b0;
			repeat (3) @(negedge i_clock);
			`CHK({sflag, cflag}, {~s[0], 1'b1})
			clear_flags;
		end
	endtask : t_wake
	task automatic final_report;
		$display("checked %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : final_report
	initial begin
		{i_rst, dse, dsel, wake, sleep, clr_s, clr_c, tx_seen} = 8'h80;
		tab = 8'h02;
		mismatches = 0;
		checked = 0;
		repeat (10) @(negedge i_clock);
		i_rst = 1'b0;
		repeat (4) @(negedge i_clock);
		`CHK(tx, 1'b1)
		t_write(1'b0, 6'h05, 8'h91, 2);
		t_write(1'b1, 6'h05, 8'h91, 0);
		t_write(1'b1, 6'h2a, 8'h99, 2);
		t_write(1'b0, 6'h05, 8'ha1, 0);
		t_read(1'b0);
		t_read(1'b1);
		t_break;
		t_wake;
		final_report;
	end
	initial begin
		repeat (100000) @(posedge i_clock);
		mismatches++;
		final_report;
	end
endmodule : test_uart_host_frame_interface
`default_nettype wire
